// File: design/acp_pkg.sv
package acp_pkg;

  // ---------------------------------------------------------------
  // register map (word index = byte offset / 4)
  // ---------------------------------------------------------------
  localparam logic [7:0] ACP_REG_STATUS   = 8'h00;
  localparam logic [7:0] ACP_REG_ERRCODE  = 8'h04;
  localparam logic [7:0] ACP_REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] ACP_REG_IRQ_EN   = 8'h0C;
  localparam logic [7:0] ACP_REG_IRQ_CLR  = 8'h10;
  localparam logic [7:0] ACP_REG_CONFIG   = 8'h14;

  // ---------------------------------------------------------------
  // error codes
  // ---------------------------------------------------------------
  localparam logic [15:0] ACP_ERR_NONE        = 16'h0000;
  localparam logic [15:0] ACP_ERR_NO_ORIGIN   = 16'h1080;
  localparam logic [15:0] ACP_ERR_REPEAT_RNG  = 16'h1081;
  localparam logic [15:0] ACP_ERR_SUP_MODE    = 16'h1082;
  localparam logic [15:0] ACP_ERR_SUP_HALT    = 16'h1083;
  localparam logic [15:0] ACP_ERR_PRESET_RNG  = 16'h1090;
  localparam logic [15:0] ACP_ERR_PRESET_MODE = 16'h1091;
  localparam logic [15:0] ACP_ERR_NO_TORQUE   = 16'h10A0;
  localparam logic [15:0] ACP_ERR_NO_TGT_TRQ  = 16'h10A1;
  localparam logic [15:0] ACP_ERR_NO_HOMING   = 16'h10B0;
  localparam logic [15:0] ACP_ERR_HOME_FAULT  = 16'h10B1;
  localparam logic [15:0] ACP_ERR_HOME_MOVING = 16'h10B2;
  localparam logic [15:0] ACP_ERR_OVR_MODE    = 16'h10C0;
  localparam logic [15:0] ACP_ERR_OVR_FACTOR  = 16'h10C1;
  localparam logic [15:0] ACP_ERR_OVR_SPEED   = 16'h10C2;

  // ---------------------------------------------------------------
  // commands, motion modes
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ACP_CMD_ABS_MOVE  = 4'h1,
    ACP_CMD_REL_MOVE  = 4'h2,
    ACP_CMD_SUP_MOVE  = 4'h3,
    ACP_CMD_SUP_HALT  = 4'h4,
    ACP_CMD_PRESET    = 4'h5,
    ACP_CMD_TORQUE    = 4'h6,
    ACP_CMD_HOME      = 4'h7,
    ACP_CMD_OVERRIDE  = 4'h8,
    ACP_CMD_SPEED     = 4'h9,
    ACP_CMD_STOP      = 4'hA
  } acp_cmd_t;

  typedef enum logic [2:0] {
    ACP_MODE_IDLE   = 3'h0,
    ACP_MODE_POS    = 3'h1,
    ACP_MODE_SPEED  = 3'h2,
    ACP_MODE_TORQUE = 3'h3,
    ACP_MODE_HOMING = 3'h4,
    ACP_MODE_SYNC   = 3'h5,
    ACP_MODE_CAM    = 3'h6
  } acp_mode_t;

  // ---------------------------------------------------------------
  // field positions, reset values
  // ---------------------------------------------------------------
  localparam int ACP_IRQ_REJECT_BIT = 0;
  localparam int ACP_IRQ_ACCEPT_BIT = 1;
  localparam int ACP_IRQ_ABORT_BIT  = 2;
  localparam int ACP_IRQ_W          = 3;
  localparam logic [ACP_IRQ_W-1:0] ACP_IRQ_EN_RST = 3'h0;
  localparam logic [7:0]           ACP_FACTOR_ONE = 8'h64; // 100 percent

endpackage

// File: design/acp_speed_check.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// override speed check: scaled speed must not pass the axis maximum
// ---------------------------------------------------------------
module acp_speed_check #(
  parameter int SPEED_W = 32,
  parameter int FACT_W  = 8
) (
  input  wire logic [SPEED_W-1:0] cur_speed,
  input  wire logic [FACT_W-1:0]  vel_factor,
  input  wire logic [SPEED_W-1:0] max_speed,
  output      logic               too_fast
);
  import acp_pkg::*;

  logic [SPEED_W+FACT_W-1:0] scaled;
  logic [SPEED_W+FACT_W-1:0] limit;

  // compare speed*factor against max*100, avoiding a divider
  always_comb begin
    scaled   = cur_speed * vel_factor;
    limit    = max_speed * (SPEED_W+FACT_W)'(ACP_FACTOR_ONE);
    too_fast = scaled > limit;
  end
endmodule // acp_speed_check

// File: design/acp_range_check.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// signed window check, inclusive on both bounds
// ---------------------------------------------------------------
module acp_range_check #(
  parameter int POS_W = 32
) (
  input  wire logic signed [POS_W-1:0] value,
  input  wire logic signed [POS_W-1:0] low,
  input  wire logic signed [POS_W-1:0] high,
  output      logic                    outside
);
  // a window with low above high rejects everything
  assign outside = (value < low) || (value > high);
endmodule // acp_range_check

// File: design/acp_precheck.sv
`timescale 1ns/100ps
module acp_precheck #(
  parameter int POS_W   = 32,
  parameter int SPEED_W = 32,
  parameter int FACT_W  = 8
) (
  input  wire logic                    ref_clk,
  input  wire logic                    srst,
  // command port
  input  wire logic                    cmd_valid,
  input  wire acp_pkg::acp_cmd_t       cmd_code,
  input  wire logic signed [POS_W-1:0] cmd_position,
  input  wire logic                    cmd_dir_neg,
  input  wire logic [FACT_W-1:0]       override_velocity_factor,
  input  wire logic [FACT_W-1:0]       override_acceleration_factor,
  input  wire logic [FACT_W-1:0]       override_jerk_factor,
  output      logic                    cmd_accept,
  output      logic                    cmd_reject,
  // axis and drive state
  input  wire logic                    origin_determined,
  input  wire logic                    axis_standstill,
  input  wire logic                    drive_fault,
  input  wire logic                    drive_has_torque_mode,
  input  wire logic                    drive_has_homing_mode,
  input  wire logic                    rxpdo_has_target_torque,
  input  wire logic                    homing_done,
  input  wire logic [SPEED_W-1:0]      cur_speed,
  input  wire logic [SPEED_W-1:0]      max_speed,
  input  wire logic signed [POS_W-1:0] soft_lower_limit,
  input  wire logic signed [POS_W-1:0] soft_upper_limit,
  input  wire logic signed [POS_W-1:0] repeat_low,
  input  wire logic signed [POS_W-1:0] repeat_high,
  output      acp_pkg::acp_mode_t      motion_mode,
  output      logic                    superimposed_active,
  output      logic                    homing_abort,
  // register port
  input  wire logic [7:0]              reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output      logic [31:0]             reg_rdata,
  output      logic                    irq
);
  import acp_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    acp_mode_t            mode;
    logic                 sup;
    logic [15:0]          err_code;
    logic                 err_flag;
    logic                 repeat_en;
    logic [ACP_IRQ_W-1:0] irq_stat;
    logic [ACP_IRQ_W-1:0] irq_en;
    logic                 accept;
    logic                 reject;
    logic                 abort;
    logic [31:0]          rdata;
  } acp_state_t;

  acp_state_t state_r;
  acp_state_t state_nxt;

  logic        preset_out;
  logic        repeat_out;
  logic        too_fast;
  logic [15:0] chk_code;
  logic signed [POS_W-1:0] rep_lo;
  logic signed [POS_W-1:0] rep_hi;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic is_moving(input acp_mode_t m);
    is_moving = (m != ACP_MODE_IDLE);
  endfunction

  // direction does not change the repeat window: forward and reverse
  // are both checked against the full window, low bound to high bound
  always_comb begin
    rep_lo = cmd_dir_neg ? repeat_low  : repeat_low;
    rep_hi = cmd_dir_neg ? repeat_high : repeat_high;
  end

  acp_range_check #(.POS_W(POS_W)) u_preset_rng (
    .value   (cmd_position),
    .low     (soft_lower_limit),
    .high    (soft_upper_limit),
    .outside (preset_out)
  );

  acp_range_check #(.POS_W(POS_W)) u_repeat_rng (
    .value   (cmd_position),
    .low     (rep_lo),
    .high    (rep_hi),
    .outside (repeat_out)
  );

  acp_speed_check #(.SPEED_W(SPEED_W), .FACT_W(FACT_W)) u_speed (
    .cur_speed  (cur_speed),
    .vel_factor (override_velocity_factor),
    .max_speed  (max_speed),
    .too_fast   (too_fast)
  );

  // ---------------------------------------------------------------
  // precondition check, first failing check wins
  // ---------------------------------------------------------------
  always_comb begin
    chk_code = ACP_ERR_NONE;
    case (cmd_code)
      ACP_CMD_ABS_MOVE: begin
        if (!origin_determined)
          chk_code = ACP_ERR_NO_ORIGIN;
        else if (state_r.repeat_en && repeat_out)
          chk_code = ACP_ERR_REPEAT_RNG;
      end
      ACP_CMD_SUP_MOVE: begin
        if (state_r.mode == ACP_MODE_SPEED || state_r.mode == ACP_MODE_TORQUE)
          chk_code = ACP_ERR_SUP_MODE;
      end
      ACP_CMD_SUP_HALT: begin
        if (!state_r.sup)
          chk_code = ACP_ERR_SUP_HALT;
      end
      ACP_CMD_PRESET: begin
        if (state_r.mode == ACP_MODE_HOMING || state_r.mode == ACP_MODE_SYNC ||
            state_r.mode == ACP_MODE_CAM || state_r.mode == ACP_MODE_TORQUE)
          chk_code = ACP_ERR_PRESET_MODE;
        else if (preset_out)
          chk_code = ACP_ERR_PRESET_RNG;
      end
      ACP_CMD_TORQUE: begin
        if (!drive_has_torque_mode)
          chk_code = ACP_ERR_NO_TORQUE;
        else if (!rxpdo_has_target_torque)
          chk_code = ACP_ERR_NO_TGT_TRQ;
      end
      ACP_CMD_HOME: begin
        if (!drive_has_homing_mode)
          chk_code = ACP_ERR_NO_HOMING;
        else if (is_moving(state_r.mode) || !axis_standstill)
          chk_code = ACP_ERR_HOME_MOVING;
      end
      ACP_CMD_OVERRIDE: begin
        if (state_r.mode != ACP_MODE_POS && state_r.mode != ACP_MODE_SPEED)
          chk_code = ACP_ERR_OVR_MODE;
        else if (override_velocity_factor == '0 ||
                 override_acceleration_factor == '0 ||
                 override_jerk_factor == '0)
          chk_code = ACP_ERR_OVR_FACTOR;
        else if (too_fast)
          chk_code = ACP_ERR_OVR_SPEED;
      end
      default: begin
        chk_code = ACP_ERR_NONE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt        = state_r;
    state_nxt.accept = 1'b0;
    state_nxt.reject = 1'b0;
    state_nxt.abort  = 1'b0;
    state_nxt.rdata  = 32'h0000_0000;

    // homing ends normally, or is torn down on a drive fault
    if (state_r.mode == ACP_MODE_HOMING) begin
      if (drive_fault) begin
        state_nxt.mode     = ACP_MODE_IDLE;
        state_nxt.abort    = 1'b1;
        state_nxt.err_code = ACP_ERR_HOME_FAULT;
        state_nxt.err_flag = 1'b1;
      end else if (homing_done) begin
        state_nxt.mode = ACP_MODE_IDLE;
      end
    end

    // a command only runs when no abort took this cycle
    if (cmd_valid && !state_nxt.abort) begin
      if (chk_code != ACP_ERR_NONE) begin
        // mode and superimposed flag left untouched
        state_nxt.reject   = 1'b1;
        state_nxt.err_code = chk_code;
        state_nxt.err_flag = 1'b1;
      end else begin
        state_nxt.accept = 1'b1;
        case (cmd_code)
          ACP_CMD_ABS_MOVE,
          ACP_CMD_REL_MOVE: state_nxt.mode = ACP_MODE_POS;
          ACP_CMD_SPEED:    state_nxt.mode = ACP_MODE_SPEED;
          ACP_CMD_TORQUE:   state_nxt.mode = ACP_MODE_TORQUE;
          ACP_CMD_HOME:     state_nxt.mode = ACP_MODE_HOMING;
          ACP_CMD_SUP_MOVE: state_nxt.sup  = 1'b1;
          ACP_CMD_SUP_HALT: state_nxt.sup  = 1'b0;
          ACP_CMD_STOP: begin
            state_nxt.mode = ACP_MODE_IDLE;
            state_nxt.sup  = 1'b0;
          end
          default: begin
            state_nxt.mode = state_r.mode;
          end
        endcase
      end
    end

    // register writes; the status clear yields to a same-cycle event
    if (reg_wr) begin
      case (reg_addr)
        ACP_REG_STATUS:  state_nxt.err_flag = state_nxt.err_flag & ~reg_wdata[0] |
                                              state_nxt.reject | state_nxt.abort;
        ACP_REG_IRQ_EN:  state_nxt.irq_en   = reg_wdata[ACP_IRQ_W-1:0];
        ACP_REG_IRQ_CLR: state_nxt.irq_stat = state_r.irq_stat & ~reg_wdata[ACP_IRQ_W-1:0];
        ACP_REG_CONFIG:  state_nxt.repeat_en = reg_wdata[0];
        default:         state_nxt.irq_en   = state_r.irq_en;
      endcase
    end

    // sticky events, set wins over clear
    if (state_nxt.reject) state_nxt.irq_stat[ACP_IRQ_REJECT_BIT] = 1'b1;
    if (state_nxt.accept) state_nxt.irq_stat[ACP_IRQ_ACCEPT_BIT] = 1'b1;
    if (state_nxt.abort)  state_nxt.irq_stat[ACP_IRQ_ABORT_BIT]  = 1'b1;

    // read data for the cycle after the strobe; unmapped reads zero
    if (reg_rd) begin
      case (reg_addr)
        ACP_REG_STATUS:   state_nxt.rdata = {26'h000_0000, state_r.mode,
                                             state_r.repeat_en, state_r.sup,
                                             state_r.err_flag};
        ACP_REG_ERRCODE:  state_nxt.rdata = {16'h0000, state_r.err_code};
        ACP_REG_IRQ_STAT: state_nxt.rdata = {29'h0000_0000, state_r.irq_stat};
        ACP_REG_IRQ_EN:   state_nxt.rdata = {29'h0000_0000, state_r.irq_en};
        ACP_REG_CONFIG:   state_nxt.rdata = {31'h0000_0000, state_r.repeat_en};
        default:          state_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r          <= '0;
      state_r.mode     <= ACP_MODE_IDLE;
      state_r.err_code <= ACP_ERR_NONE;
      state_r.irq_en   <= ACP_IRQ_EN_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign cmd_accept          = state_r.accept;
  assign cmd_reject          = state_r.reject;
  assign homing_abort        = state_r.abort;
  assign motion_mode         = state_r.mode;
  assign superimposed_active = state_r.sup;
  assign reg_rdata           = state_r.rdata;
  assign irq                 = |(state_r.irq_stat & state_r.irq_en);

endmodule // acp_precheck

// File: verification/acp_precheck_sva.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// port checks for the command precheck block
// ---------------------------------------------------------------
module acp_precheck_sva
  import acp_pkg::*;
#(
  parameter int FACT_W = 8
) (
  input wire logic               ref_clk,
  input wire logic               srst,
  input wire logic               cmd_valid,
  input wire acp_pkg::acp_cmd_t  cmd_code,
  input wire logic [FACT_W-1:0]  override_velocity_factor,
  input wire logic [FACT_W-1:0]  override_acceleration_factor,
  input wire logic [FACT_W-1:0]  override_jerk_factor,
  input wire logic               origin_determined,
  input wire logic               drive_fault,
  input wire logic               cmd_accept,
  input wire logic               cmd_reject,
  input wire acp_pkg::acp_mode_t motion_mode,
  input wire logic               superimposed_active,
  input wire logic               homing_abort,
  input wire logic               reg_rd,
  input wire logic [31:0]        reg_rdata
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);

  // a drive fault while homing swallows any command of that cycle
  sequence s_abort_cause;
    motion_mode == ACP_MODE_HOMING && drive_fault;
  endsequence
  sequence s_take;
    cmd_valid && !(motion_mode == ACP_MODE_HOMING && drive_fault);
  endsequence

  one_answer_a: assert property (s_take |=> cmd_accept ^ cmd_reject)
    else $error("command not answered by exactly one pulse");
  no_spurious_a: assert property ((cmd_accept || cmd_reject) |-> $past(cmd_valid))
    else $error("answer without a command");
  reject_hold_a: assert property (cmd_reject |-> motion_mode == $past(motion_mode)
    && superimposed_active == $past(superimposed_active)) else $error("reject moved the axis");
  no_origin_a: assert property (s_take ##0 (cmd_code == ACP_CMD_ABS_MOVE
    && !origin_determined) |=> cmd_reject) else $error("absolute move without origin taken");
  sup_mode_a: assert property (s_take ##0 (cmd_code == ACP_CMD_SUP_MOVE
    && motion_mode inside {ACP_MODE_SPEED, ACP_MODE_TORQUE}) |=> cmd_reject)
    else $error("superimposed move taken in speed or torque mode");
  sup_halt_a: assert property (s_take ##0 (cmd_code == ACP_CMD_SUP_HALT
    && !superimposed_active) |=> cmd_reject) else $error("halt taken with no superimposed motion");
  ovr_refuse_a: assert property (s_take ##0 (cmd_code == ACP_CMD_OVERRIDE
    && (!(motion_mode inside {ACP_MODE_POS, ACP_MODE_SPEED}) || override_velocity_factor == 0
    || override_acceleration_factor == 0 || override_jerk_factor == 0)) |=> cmd_reject)
    else $error("override taken in wrong mode or with zero factor");
  home_abort_a: assert property (s_abort_cause |=> homing_abort
    && motion_mode == ACP_MODE_IDLE) else $error("drive fault did not abort homing");
  abort_cause_a: assert property (homing_abort |-> $past(motion_mode) == ACP_MODE_HOMING
    && $past(drive_fault)) else $error("homing abort without a fault while homing");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside the read answer cycle");
endmodule // acp_precheck_sva

bind acp_precheck acp_precheck_sva #(.FACT_W(FACT_W)) u_sva (.ref_clk, .srst, .cmd_valid,
  .cmd_code, .override_velocity_factor, .override_acceleration_factor, .override_jerk_factor,
  .origin_determined, .drive_fault, .cmd_accept, .cmd_reject, .motion_mode,
  .superimposed_active, .homing_abort, .reg_rd, .reg_rdata);

// File: verification/acp_drive_model.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// servo drive seen from the axis: capabilities, homing, faults
// ---------------------------------------------------------------
module acp_drive_model (
  input  wire logic               ref_clk,
  input  wire logic               srst,
  input  wire acp_pkg::acp_mode_t motion_mode,
  input  wire logic [2:0]         caps,
  input  wire logic               fault_req,
  input  wire logic               slow,
  output      logic               drive_fault,
  output      logic               drive_has_torque_mode,
  output      logic               drive_has_homing_mode,
  output      logic               rxpdo_has_target_torque,
  output      logic               axis_standstill,
  output      logic               homing_done
);
  import acp_pkg::*;
  logic [7:0] home_cnt_r;
  // caps: [0] torque mode, [1] homing mode, [2] target torque mapped
  assign drive_has_torque_mode   = caps[0];
  assign drive_has_homing_mode   = caps[1];
  assign rxpdo_has_target_torque = caps[2];
  // fault follows fault_req after eight homing cycles and drops when fault_req falls or the axis leaves homing
  always_ff @(posedge ref_clk) begin
    if (srst || motion_mode != ACP_MODE_HOMING) begin
      home_cnt_r  <= 8'h00;
      drive_fault <= 1'b0;
      homing_done <= 1'b0;
    end else begin
      home_cnt_r  <= home_cnt_r + 8'h01;
      drive_fault <= fault_req && home_cnt_r >= 8'h08;
      homing_done <= !fault_req && home_cnt_r == (slow ? 8'h14 : 8'h04);
    end
    axis_standstill <= srst || motion_mode == ACP_MODE_IDLE;
  end
endmodule // acp_drive_model

// File: verification/test_acp_precheck.sv
`timescale 1ns/100ps
`define CHK(got, want) begin \
  samples_checked++; \
  if ((got) !== (want)) begin \
    errors++; \
    $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, want); \
  end \
end
module test_acp_precheck;
  import acp_pkg::*;
  logic               ref_clk, srst, cmd_valid, cmd_dir_neg, origin_determined, reg_wr, reg_rd;
  logic               fault_req, slow, rd_seen, cmd_accept, cmd_reject, superimposed_active, irq;
  logic               homing_abort, drive_fault, drive_has_torque_mode, drive_has_homing_mode;
  logic               rxpdo_has_target_torque, axis_standstill, homing_done;
  logic [2:0]         caps;
  logic [7:0]         override_velocity_factor, override_acceleration_factor;
  logic [7:0]         override_jerk_factor, reg_addr, v;
  logic [31:0]        cur_speed, max_speed, reg_wdata, reg_rdata, e, seed;
  logic signed [31:0] cmd_position, soft_lower_limit, soft_upper_limit, repeat_low, repeat_high;
  logic signed [31:0] pv;
  acp_cmd_t           cmd_code;
  acp_mode_t          motion_mode;
  logic [31:0]        exp_q[$];
  int                 errors = 0;
  int                 samples_checked = 0;

  acp_precheck u_dut (.ref_clk, .srst, .cmd_valid, .cmd_code, .cmd_position, .cmd_dir_neg,
    .override_velocity_factor, .override_acceleration_factor, .override_jerk_factor,
    .cmd_accept, .cmd_reject, .origin_determined, .axis_standstill, .drive_fault,
    .drive_has_torque_mode, .drive_has_homing_mode, .rxpdo_has_target_torque, .homing_done,
    .cur_speed, .max_speed, .soft_lower_limit, .soft_upper_limit, .repeat_low, .repeat_high,
    .motion_mode, .superimposed_active, .homing_abort, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .irq);
  acp_drive_model u_drive (.ref_clk, .srst, .motion_mode, .caps, .fault_req, .slow,
    .drive_fault, .drive_has_torque_mode, .drive_has_homing_mode, .rxpdo_has_target_torque,
    .axis_standstill, .homing_done);

  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // each task leaves one idle edge so a strobe is never lowered and raised in one step
  task automatic wr(logic [7:0] a, logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] d);
    exp_q.push_back(d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask
  // a refused command is followed by a read of the latched code
  task automatic cmd(acp_cmd_t c, logic signed [31:0] p, logic [15:0] ec);
    exp_q.push_back(ec == ACP_ERR_NONE ? 32'h2 : 32'h1);
    cmd_code     <= c;
    cmd_position <= p;
    cmd_dir_neg  <= seed[0];
    cmd_valid    <= 1'b1;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    @(posedge ref_clk);
    if (ec != ACP_ERR_NONE) rd(ACP_REG_ERRCODE, {16'h0, ec});
  endtask
  task automatic give_verdict();
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // results are compared in mid-cycle, oldest note first
  always @(negedge ref_clk) begin
    if (rd_seen || cmd_accept || cmd_reject) begin
      e = exp_q.size() ? exp_q.pop_front() : 32'hDEADBEEF;
      if (rd_seen) `CHK(reg_rdata, e)
      else `CHK({30'h0, cmd_accept, cmd_reject}, e)
    end
    rd_seen = reg_rd;
  end

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (4000) @(posedge ref_clk);
    errors++;
    give_verdict();
  end

  initial begin
    srst = 1'b1;
    {cmd_valid, cmd_dir_neg, origin_determined, reg_wr, reg_rd, fault_req, rd_seen} = '0;
    {caps, slow, seed, cmd_code} = {3'h7, 1'b1, 32'h6C111EBD, ACP_CMD_STOP};
    {reg_addr, reg_wdata, cmd_position, cur_speed, max_speed} = {8'h00, 64'h0, 32'h1F4, 32'h3E8};
    {override_velocity_factor, override_acceleration_factor, override_jerk_factor} = 24'h646464;
    {soft_lower_limit, soft_upper_limit} = {-32'sd1000, 32'sd1000};
    {repeat_low, repeat_high} = {-32'sd500, 32'sd500};
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    wr(ACP_REG_IRQ_EN, 32'h1);
    cmd(ACP_CMD_ABS_MOVE, 0, ACP_ERR_NO_ORIGIN);
    cmd(ACP_CMD_REL_MOVE, 0, ACP_ERR_NONE);
    @(negedge ref_clk); `CHK(irq, 1'b1)
    @(posedge ref_clk);
    rd(ACP_REG_IRQ_STAT, 32'h3);
    wr(ACP_REG_IRQ_CLR, 32'h7);
    rd(8'h3C, 32'h0);
    @(negedge ref_clk); `CHK(irq, 1'b0)
    @(posedge ref_clk);
    origin_determined <= 1'b1;
    wr(ACP_REG_CONFIG, 32'h1);
    cmd(ACP_CMD_ABS_MOVE, 501, ACP_ERR_REPEAT_RNG);
    cmd(ACP_CMD_ABS_MOVE, 500, ACP_ERR_NONE);
    cmd(ACP_CMD_SUP_HALT, 0, ACP_ERR_SUP_HALT);
    cmd(ACP_CMD_SUP_MOVE, 0, ACP_ERR_NONE);
    cmd(ACP_CMD_SUP_HALT, 0, ACP_ERR_NONE);
    cmd(ACP_CMD_HOME, 0, ACP_ERR_HOME_MOVING);
    // zero factors, the exact speed boundary, then random velocity factors
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      v = (i == 3) ? 8'hC8 : (i == 4) ? 8'hC9 : (seed[7:0] | 8'h01);
      override_velocity_factor     <= (i == 0) ? 8'h00 : v;
      override_acceleration_factor <= (i == 1) ? 8'h00 : 8'h64;
      override_jerk_factor         <= (i == 2) ? 8'h00 : (seed[15:8] | 8'h01);
      cmd(ACP_CMD_OVERRIDE, 0, (i < 3) ? ACP_ERR_OVR_FACTOR :
          (v > 8'hC8) ? ACP_ERR_OVR_SPEED : ACP_ERR_NONE);
    end
    cmd(ACP_CMD_STOP, 0, ACP_ERR_NONE);
    cmd(ACP_CMD_OVERRIDE, 0, ACP_ERR_OVR_MODE);
    cmd(ACP_CMD_SPEED, 0, ACP_ERR_NONE);
    cmd(ACP_CMD_SUP_MOVE, 0, ACP_ERR_SUP_MODE);
    for (int i = 0; i < 10; i++) begin
      seed = xs(seed);
      pv = (i == 0) ? 32'sd1000 : (i == 1) ? -32'sd1001 : {{20{seed[11]}}, seed[11:0]};
      cmd(ACP_CMD_PRESET, pv, (pv > 1000 || pv < -1000) ? ACP_ERR_PRESET_RNG : ACP_ERR_NONE);
    end
    cmd(ACP_CMD_STOP, 0, ACP_ERR_NONE);
    caps <= 3'h6;
    cmd(ACP_CMD_TORQUE, 0, ACP_ERR_NO_TORQUE);
    caps <= 3'h3;
    cmd(ACP_CMD_TORQUE, 0, ACP_ERR_NO_TGT_TRQ);
    caps <= 3'h7;
    cmd(ACP_CMD_TORQUE, 0, ACP_ERR_NONE);
    cmd(ACP_CMD_PRESET, 0, ACP_ERR_PRESET_MODE);
    cmd(ACP_CMD_SUP_MOVE, 0, ACP_ERR_SUP_MODE);
    rd(ACP_REG_STATUS, 32'h1D);
    cmd(ACP_CMD_STOP, 0, ACP_ERR_NONE);
    caps <= 3'h5;
    cmd(ACP_CMD_HOME, 0, ACP_ERR_NO_HOMING);
    {caps, slow} <= {3'h7, 1'b0};
    cmd(ACP_CMD_HOME, 0, ACP_ERR_NONE);
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk); `CHK(motion_mode, ACP_MODE_IDLE)
    @(posedge ref_clk);
    {slow, fault_req} <= 2'b11;
    wr(ACP_REG_IRQ_CLR, 32'h7);
    cmd(ACP_CMD_HOME, 0, ACP_ERR_NONE);
    cmd(ACP_CMD_PRESET, 0, ACP_ERR_PRESET_MODE);
    repeat (12) @(posedge ref_clk);
    fault_req <= 1'b0;
    rd(ACP_REG_ERRCODE, {16'h0, ACP_ERR_HOME_FAULT});
    rd(ACP_REG_IRQ_STAT, 32'h7);
    @(negedge ref_clk); `CHK(motion_mode, ACP_MODE_IDLE)
    `CHK(exp_q.size(), 0)
    give_verdict();
  end
endmodule // test_acp_precheck
